// ### include/cgd_pkg.sv
// Package for the clock gate and device status block: register layout,
// reset values, startup timing figures and the sequencer states.
// Assumes a single 40 MHz system clock shared by every user of the package.
package cgd_pkg;

  // System clock rate
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned HZ_PER_MHZ   = 1_000_000;

  // Startup time limits in microseconds, as specified
  localparam int unsigned BIAS_TMO_US  = 2000;
  localparam int unsigned FUSE_TMO_US  = 10000;
  localparam int unsigned PLL_TMO_US   = 2000;

  // Same limits in system clock cycles
  localparam int unsigned BIAS_TMO_CYC = BIAS_TMO_US * (CLK_HZ / HZ_PER_MHZ);
  localparam int unsigned FUSE_TMO_CYC = FUSE_TMO_US * (CLK_HZ / HZ_PER_MHZ);
  localparam int unsigned PLL_TMO_CYC  = PLL_TMO_US * (CLK_HZ / HZ_PER_MHZ);
  // Wait for the system divider to toggle before falling back (arbitrary)
  localparam int unsigned OSC_WAIT_CYC = 256;

  // Register selection on the register port
  localparam logic        REG_IDX_GATE   = 1'h0;
  localparam logic        REG_IDX_STATUS = 1'h1;

  // Clock gating register layout
  localparam int unsigned GATE_W         = 16;
  localparam int unsigned GEN_GATE_BIT   = 11;
  localparam int unsigned ACT_B_BIT      = 5;
  localparam int unsigned ACT_A_BIT      = 4;
  localparam int unsigned XTAL_LOS_BIT   = 3;
  localparam int unsigned NEG_LOS_BIT    = 2;
  localparam int unsigned POS_LOS_BIT    = 1;
  localparam int unsigned FUSE_BIT       = 0;
  localparam logic [15:0] GATE_WR_MASK   = 16'h097f;
  localparam logic [15:0] GATE_RST       = 16'h0000;

  // Status register layout
  localparam int unsigned STS_W          = 8;
  localparam int unsigned SEQ_LSB        = 5;
  localparam int unsigned FALLBACK_BIT   = 4;
  localparam int unsigned READY_BIT      = 3;
  localparam int unsigned IDX_LSB        = 0;
  localparam int unsigned SEQ_BIAS       = 0;
  localparam int unsigned SEQ_FUSE       = 1;
  localparam int unsigned SEQ_PLL        = 2;
  localparam logic [2:0]  SEQ_RST        = 3'h0;
  localparam logic [1:0]  IDX_RST        = 2'h0;
  localparam logic [3:0]  CFG_RST        = 4'h0;

  // Startup sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_BIAS = 4'h1,
    ST_FUSE = 4'h2,
    ST_PLL  = 4'h4,
    ST_DONE = 4'h8
  } cgd_state_t;

endpackage : cgd_pkg

// ### include/cgd_tmo_if.sv
// Interface between the startup sequencer and one timeout watcher.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface cgd_tmo_if;
  logic arm;      // Watch window open
  logic done;     // Awaited event seen
  logic expired;  // Limit reached before the event
  modport mon (input arm, input done, output expired);
  modport ctl (output arm, output done, input expired);
endinterface : cgd_tmo_if
`default_nettype wire

// ### verilog/cgd_timeout.sv
// Timeout watcher: counts armed cycles and flags expiry if the awaited
// event does not arrive. Assumes arm and done are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module cgd_timeout #(
  parameter int unsigned CYCLES = 80000
) (
  input  wire logic   clk,
  input  wire logic   rstn,
  input  wire logic   ce,
  cgd_tmo_if.mon      tmo
);
  localparam int unsigned W = $clog2(CYCLES + 1);

  if (CYCLES < 1) begin : g_bad_cycles
    $error("cgd_timeout: CYCLES must be at least 1");
  end

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         exp_reg;
  logic         exp_next;

  // Count only while armed and still waiting; disarm clears everything
  always_comb begin
    cnt_next = cnt_reg;
    exp_next = exp_reg;
    if (!tmo.arm) begin
      cnt_next = '0;
      exp_next = 1'b0;
    end else if (!tmo.done && !exp_reg) begin
      if (cnt_reg == W'(CYCLES - 1)) begin
        exp_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_reg <= '0;
      exp_reg <= 1'b0;
    end else if (ce) begin
      cnt_reg <= cnt_next;
      exp_reg <= exp_next;
    end
  end

  assign tmo.expired = exp_reg;

  // Expiry only after the full count
  property p_expire_at_limit;
    @(posedge clk) disable iff (!rstn)
      $rose(exp_reg) |-> $past(cnt_reg) == W'(CYCLES - 1);
  endproperty
  a_expire_at_limit: assert property (p_expire_at_limit) else $error("early expiry");

  property p_expire_needs_arm;
    @(posedge clk) disable iff (!rstn)
      (ce && !tmo.arm) |=> !exp_reg;
  endproperty
  a_expire_needs_arm: assert property (p_expire_needs_arm) else $error("expiry kept");

endmodule : cgd_timeout
`default_nettype wire

// ### verilog/cgd_top.sv
// Clock gate control and device status: gating register, startup
// sequencer with timeouts, ring oscillator fallback and status register.
// Assumes rstn is the power-on reset; analog flags arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
module cgd_top
  import cgd_pkg::*;
#(
  parameter int unsigned BIAS_CYC = BIAS_TMO_CYC,
  parameter int unsigned FUSE_CYC = FUSE_TMO_CYC,
  parameter int unsigned PLL_CYC  = PLL_TMO_CYC,
  parameter int unsigned OSC_CYC  = OSC_WAIT_CYC
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic        reg_idx,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        bias_done_pin,
  input  wire logic        pll_lock_pin,
  input  wire logic        sysdiv_pin,
  input  wire logic        fuse_load_done,
  input  wire logic [3:0]  config_sel,
  output logic             fuse_load_req,
  output logic             fuse_load_common,
  output logic      [3:0]  fuse_cfg_sel,
  output logic             ring_osc_sel,
  output logic             general_logic_gate,
  output logic             activity_mon_b_gate,
  output logic             activity_mon_a_gate,
  output logic             xtal_loss_mon_gate,
  output logic             neg_input_loss_mon_gate,
  output logic             pos_input_loss_mon_gate,
  output logic             fuse_port_gate
);

  if (BIAS_CYC < 1 || FUSE_CYC < 1 || PLL_CYC < 1 || OSC_CYC < 1) begin : g_bad
    $error("cgd_top: timeout counts must be at least 1");
  end
  // Two-stage synchronisers for the asynchronous analog flags
  logic [2:0] sync1_reg, sync2_reg;
  logic       div_prev_reg;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync1_reg    <= 3'h0;
      sync2_reg    <= 3'h0;
      div_prev_reg <= 1'b0;
    end else if (ce) begin
      sync1_reg    <= {sysdiv_pin, pll_lock_pin, bias_done_pin};
      sync2_reg    <= sync1_reg;
      div_prev_reg <= sync2_reg[2];
    end
  end
  wire bias_ok  = sync2_reg[0];
  wire pll_ok   = sync2_reg[1];
  wire div_edge = div_prev_reg & ~sync2_reg[2]; // Fall only; a stuck-high pin fakes no edge
  // Register state
  cgd_state_t  state_reg, state_next;
  logic [15:0] gate_reg, gate_next;
  logic [2:0]  seq_reg, seq_next;
  logic        fallback_reg, fallback_next;
  logic        div_seen_reg, div_seen_next;
  logic        ready_reg, ready_next;
  logic [1:0]  idx_reg, idx_next;
  logic [3:0]  cfg_reg, cfg_next;
  logic        load_reg, load_next;
  logic        cfg_taken_reg, cfg_taken_next;
  logic [15:0] rdata_reg, rdata_next;
  logic        rvalid_reg, rvalid_next;
  // Timeout watchers, one per startup step plus the divider watch
  cgd_tmo_if bias_tmo ();
  cgd_tmo_if fuse_tmo ();
  cgd_tmo_if pll_tmo ();
  cgd_tmo_if osc_tmo ();
  assign bias_tmo.arm  = (state_reg == ST_BIAS);
  assign bias_tmo.done = bias_ok;
  assign fuse_tmo.arm  = (state_reg == ST_FUSE) && cfg_taken_reg;
  assign fuse_tmo.done = fuse_load_done;
  assign pll_tmo.arm   = (state_reg == ST_PLL);
  assign pll_tmo.done  = pll_ok;
  assign osc_tmo.arm   = !div_seen_reg && !fallback_reg;
  assign osc_tmo.done  = div_edge;
  cgd_timeout #(.CYCLES(BIAS_CYC)) u_bias_tmo (.clk(clk), .rstn(rstn), .ce(ce), .tmo(bias_tmo));
  cgd_timeout #(.CYCLES(FUSE_CYC)) u_fuse_tmo (.clk(clk), .rstn(rstn), .ce(ce), .tmo(fuse_tmo));
  cgd_timeout #(.CYCLES(PLL_CYC))  u_pll_tmo  (.clk(clk), .rstn(rstn), .ce(ce), .tmo(pll_tmo));
  cgd_timeout #(.CYCLES(OSC_CYC))  u_osc_tmo  (.clk(clk), .rstn(rstn), .ce(ce), .tmo(osc_tmo));

  // Status word: seq flags, fallback, ready, reserved zero, index
  wire [7:0] sts_word = {seq_reg, fallback_reg, ready_reg, 1'b0, idx_reg};
  // Register bus clock stops with the general gate
  wire bus_alive   = !gate_reg[GEN_GATE_BIT];
  wire gate_wr_hit = bus_alive && reg_wr && reg_idx == REG_IDX_GATE;

  // Startup sequencer and status flags
  always_comb begin
    state_next     = state_reg;
    seq_next       = seq_reg;
    ready_next     = ready_reg;
    idx_next       = idx_reg;
    cfg_next       = cfg_reg;
    cfg_taken_next = cfg_taken_reg;
    load_next      = load_reg;
    fallback_next  = fallback_reg;
    div_seen_next  = div_seen_reg || div_edge;
    // No toggle in time: fall back once, never switch back
    if (osc_tmo.expired && !div_edge && !div_seen_reg) begin
      fallback_next = 1'b1;
    end
    unique case (state_reg)
      ST_BIAS: begin
        if (bias_ok) begin
          state_next = ST_FUSE;
        end else if (bias_tmo.expired) begin
          seq_next[SEQ_BIAS] = 1'b1;
          state_next         = ST_FUSE;
        end
      end
      ST_FUSE: begin
        // Select is captured once so a later change cannot alter the load
        if (!cfg_taken_reg) begin
          cfg_next       = config_sel;
          cfg_taken_next = 1'b1;
          load_next      = 1'b1;
        end else if (fuse_load_done) begin
          ready_next = 1'b1;
          idx_next   = cfg_reg[1:0];
          load_next  = 1'b0;
          state_next = ST_PLL;
        end else if (fuse_tmo.expired) begin
          seq_next[SEQ_FUSE] = 1'b1;
          load_next          = 1'b0;
          state_next         = ST_PLL;
        end
      end
      ST_PLL: begin
        if (pll_ok) begin
          state_next = ST_DONE;
        end else if (pll_tmo.expired) begin
          seq_next[SEQ_PLL] = 1'b1;
          state_next        = ST_DONE;
        end
      end
      ST_DONE: state_next = ST_DONE; // Terminal until the next power-on reset
    endcase
  end

  // Register port: writes to gating bits, reads of both registers
  always_comb begin
    gate_next   = gate_reg;
    rdata_next  = rdata_reg;
    rvalid_next = 1'b0;
    if (gate_wr_hit) begin
      // Reserved read-only bits and the status register take no write
      gate_next = (gate_reg & ~GATE_WR_MASK) | (reg_wdata & GATE_WR_MASK);
    end
    if (bus_alive && reg_rd) begin
      rvalid_next = 1'b1;
      rdata_next  = (reg_idx == REG_IDX_GATE) ? gate_reg : {8'h00, sts_word};
    end
    // Once set, nothing but power-on reset clears the general gate
    if (gate_reg[GEN_GATE_BIT]) begin
      gate_next[GEN_GATE_BIT] = 1'b1;
    end
  end

  // All state registers but the synchronisers; reset is the power-on reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg     <= ST_BIAS;
      gate_reg      <= GATE_RST;
      seq_reg       <= SEQ_RST;
      fallback_reg  <= 1'b0;
      div_seen_reg  <= 1'b0;
      ready_reg     <= 1'b0;
      idx_reg       <= IDX_RST;
      cfg_reg       <= CFG_RST;
      cfg_taken_reg <= 1'b0;
      load_reg      <= 1'b0;
      rdata_reg     <= 16'h0000;
      rvalid_reg    <= 1'b0;
    end else if (ce) begin
      state_reg     <= state_next;
      gate_reg      <= gate_next;
      seq_reg       <= seq_next;
      fallback_reg  <= fallback_next;
      div_seen_reg  <= div_seen_next;
      ready_reg     <= ready_next;
      idx_reg       <= idx_next;
      cfg_reg       <= cfg_next;
      cfg_taken_reg <= cfg_taken_next;
      load_reg      <= load_next;
      rdata_reg     <= rdata_next;
      rvalid_reg    <= rvalid_next;
    end
  end

  // Outputs are register bits; gate outputs feed the clock gating cells
  assign reg_rdata               = rdata_reg;
  assign reg_rvalid              = rvalid_reg;
  assign fuse_load_req           = load_reg;
  assign fuse_load_common        = load_reg;
  assign fuse_cfg_sel            = cfg_reg;
  assign ring_osc_sel            = fallback_reg;
  assign general_logic_gate      = gate_reg[GEN_GATE_BIT];
  assign activity_mon_b_gate     = gate_reg[ACT_B_BIT];
  assign activity_mon_a_gate     = gate_reg[ACT_A_BIT];
  assign xtal_loss_mon_gate      = gate_reg[XTAL_LOS_BIT];
  assign neg_input_loss_mon_gate = gate_reg[NEG_LOS_BIT];
  assign pos_input_loss_mon_gate = gate_reg[POS_LOS_BIT];
  assign fuse_port_gate          = gate_reg[FUSE_BIT];

  property p_gen_gate_sticky;
    @(posedge clk) disable iff (!rstn)
      general_logic_gate |=> general_logic_gate;
  endproperty
  a_gen_gate_sticky: assert property (p_gen_gate_sticky) else $error("gate cleared");
  property p_no_access_gated;
    @(posedge clk) disable iff (!rstn)
      general_logic_gate |=> $stable(gate_reg) && !reg_rvalid;
  endproperty
  a_no_access_gated: assert property (p_no_access_gated) else $error("access gated");
  property p_gen_write;
    @(posedge clk) disable iff (!rstn)
      (ce && gate_wr_hit) |=> general_logic_gate == $past(reg_wdata[GEN_GATE_BIT]);
  endproperty
  a_gen_write: assert property (p_gen_write) else $error("general gate write");
  property p_mon_gates;
    @(posedge clk) disable iff (!rstn)
      (ce && gate_wr_hit) |=> activity_mon_b_gate == $past(reg_wdata[ACT_B_BIT])
            && activity_mon_a_gate == $past(reg_wdata[ACT_A_BIT]);
  endproperty
  a_mon_gates: assert property (p_mon_gates) else $error("activity gate write");
  property p_los_gates;
    @(posedge clk) disable iff (!rstn)
      (ce && gate_wr_hit)
        |=> {xtal_loss_mon_gate, neg_input_loss_mon_gate, pos_input_loss_mon_gate}
            == $past(reg_wdata[XTAL_LOS_BIT:POS_LOS_BIT]);
  endproperty
  a_los_gates: assert property (p_los_gates) else $error("loss gate write");
  property p_fuse_gate;
    @(posedge clk) disable iff (!rstn)
      (ce && gate_wr_hit) |=> fuse_port_gate == $past(reg_wdata[FUSE_BIT]);
  endproperty
  a_fuse_gate: assert property (p_fuse_gate) else $error("fuse gate write");
  property p_bias_flag;
    @(posedge clk) disable iff (!rstn)
      (ce && state_reg == ST_BIAS && bias_tmo.expired && !bias_ok)
        |=> seq_reg[SEQ_BIAS] && state_reg == ST_FUSE;
  endproperty
  a_bias_flag: assert property (p_bias_flag) else $error("bias timeout flag");
  property p_fuse_flag;
    @(posedge clk) disable iff (!rstn)
      (ce && state_reg == ST_FUSE && fuse_tmo.expired && !fuse_load_done)
        |=> seq_reg[SEQ_FUSE] && !ready_reg && !fuse_load_req;
  endproperty
  a_fuse_flag: assert property (p_fuse_flag) else $error("fuse timeout flag");
  property p_pll_flag;
    @(posedge clk) disable iff (!rstn)
      (ce && state_reg == ST_PLL && pll_tmo.expired && !pll_ok) |=> seq_reg[SEQ_PLL];
  endproperty
  a_pll_flag: assert property (p_pll_flag) else $error("pll timeout flag");
  property p_ready_idx;
    @(posedge clk) disable iff (!rstn)
      (ce && state_reg == ST_FUSE && cfg_taken_reg && fuse_load_done)
        |=> ready_reg && idx_reg == $past(cfg_reg[1:0]);
  endproperty
  a_ready_idx: assert property (p_ready_idx) else $error("ready or index");
  property p_fallback;
    @(posedge clk) disable iff (!rstn)
      $rose(ring_osc_sel) |-> $past(osc_tmo.expired) && !div_seen_reg;
  endproperty
  a_fallback: assert property (p_fallback) else $error("fallback cause");

endmodule : cgd_top
`default_nettype wire

// ### tb/testbench.sv
// Self-checking testbench for the clock gate and device status block.
// Assumes cgd_pkg and the design files are compiled ahead of this file.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cgd_pkg::*;

  // Short startup limits keep the run brief; the dead-startup checks rely on all of them expiring within 200 cycles
  localparam int unsigned BIAS_N = 20;
  localparam int unsigned FUSE_N = 40;
  localparam int unsigned PLL_N  = 20;
  localparam int unsigned OSC_N  = 16;
  localparam int          LIMIT  = 5000;

  logic        clk;
  logic        rstn;
  logic        ce;
  logic        reg_wr;
  logic        reg_rd;
  logic        reg_idx;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        reg_rvalid;
  logic        bias_done_pin;
  logic        pll_lock_pin;
  logic        sysdiv_pin;
  logic        fuse_load_done;
  logic [3:0]  config_sel;
  logic        fuse_load_req;
  logic        fuse_load_common;
  logic [3:0]  fuse_cfg_sel;
  logic        ring_osc_sel;
  logic        general_logic_gate;
  logic        activity_mon_b_gate;
  logic        activity_mon_a_gate;
  logic        xtal_loss_mon_gate;
  logic        neg_input_loss_mon_gate;
  logic        pos_input_loss_mon_gate;
  logic        fuse_port_gate;
  logic        div_run;
  int          fails;
  int          num_checks;
  int          cycles;

  cgd_top #(
    .BIAS_CYC (BIAS_N),
    .FUSE_CYC (FUSE_N),
    .PLL_CYC  (PLL_N),
    .OSC_CYC  (OSC_N)
  ) u_cgd_top (
    .clk                     (clk),
    .rstn                    (rstn),
    .ce                      (ce),
    .reg_wr                  (reg_wr),
    .reg_rd                  (reg_rd),
    .reg_idx                 (reg_idx),
    .reg_wdata               (reg_wdata),
    .reg_rdata               (reg_rdata),
    .reg_rvalid              (reg_rvalid),
    .bias_done_pin           (bias_done_pin),
    .pll_lock_pin            (pll_lock_pin),
    .sysdiv_pin              (sysdiv_pin),
    .fuse_load_done          (fuse_load_done),
    .config_sel              (config_sel),
    .fuse_load_req           (fuse_load_req),
    .fuse_load_common        (fuse_load_common),
    .fuse_cfg_sel            (fuse_cfg_sel),
    .ring_osc_sel            (ring_osc_sel),
    .general_logic_gate      (general_logic_gate),
    .activity_mon_b_gate     (activity_mon_b_gate),
    .activity_mon_a_gate     (activity_mon_a_gate),
    .xtal_loss_mon_gate      (xtal_loss_mon_gate),
    .neg_input_loss_mon_gate (neg_input_loss_mon_gate),
    .pos_input_loss_mon_gate (pos_input_loss_mon_gate),
    .fuse_port_gate          (fuse_port_gate)
  );

  // 40 MHz system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // System divider stand-in; stays still when a dead divider is wanted
  always @(posedge clk) begin
    #1;
    if (div_run) sysdiv_pin = ~sysdiv_pin;
  end

  // Hang guard: a stuck wait ends the run instead of the simulator limit
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      $display("CHECK FAILED timeout expected finish seen hang");
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // All gate pins as one vector, general gate on top
  function automatic logic [15:0] gates();
    return {9'h0, general_logic_gate, activity_mon_b_gate, activity_mon_a_gate,
            xtal_loss_mon_gate, neg_input_loss_mon_gate, pos_input_loss_mon_gate,
            fuse_port_gate};
  endfunction : gates

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // One-cycle write strobe; gate pins show the result one cycle later
  task automatic wr(input logic idx, input logic [15:0] d);
    tick(1);
    reg_wr    = 1'b1;
    reg_idx   = idx;
    reg_wdata = d;
    tick(1);
    reg_wr    = 1'b0;
  endtask : wr

  // One-cycle read strobe; valid pulse and data are sampled in the next cycle
  task automatic rd(input logic idx, input logic vld, input logic [15:0] exp,
                    input string name);
    tick(1);
    reg_rd  = 1'b1;
    reg_idx = idx;
    tick(1);
    reg_rd  = 1'b0;
    check({name, "_valid"}, {15'h0, vld}, {15'h0, reg_rvalid});
    if (vld) check(name, exp, reg_rdata);
  endtask : rd

  // Reset stands in for a full power cycle
  task automatic do_reset();
    rstn = 1'b0;
    tick(12);
    rstn = 1'b1;
  endtask : do_reset

  initial begin
    rstn = 1'b0; ce = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_idx = 1'b0;
    reg_wdata = 16'h0000; bias_done_pin = 1'b1; pll_lock_pin = 1'b1;
    sysdiv_pin = 1'b0; fuse_load_done = 1'b0; config_sel = 4'h6; div_run = 1'b1;
    fails = 0; num_checks = 0; cycles = 0;
    // Healthy startup: every step answers in time, divider toggles
    do_reset();
    check("gates_after_reset", 16'h0000, gates());
    rd(1'b0, 1'b1, 16'h0000, "gate_reg_reset");
    rd(1'b1, 1'b1, 16'h0000, "status_reset");
    for (int i = 0; i < 50 && fuse_load_req !== 1'b1; i++) tick(1);
    check("load_req", 16'h0001, {15'h0, fuse_load_req});
    check("load_common", 16'h0001, {15'h0, fuse_load_common});
    check("cfg_sel_out", 16'h0006, {12'h0, fuse_cfg_sel});
    tick(3);
    check("fuse_gate_open", 16'h0000, {15'h0, fuse_port_gate});
    fuse_load_done = 1'b1; // loader stand-in never touches the gating bits
    tick(1);
    fuse_load_done = 1'b0;
    check("load_req_drop", 16'h0000, {15'h0, fuse_load_req});
    check("gates_after_load", 16'h0000, gates());
    tick(10);
    // Ready bit 3 and index 2 from select 6, no timeout, no fallback
    rd(1'b1, 1'b1, 16'h000a, "status_good");
    check("ring_osc_good", 16'h0000, {15'h0, ring_osc_sel});
    // Each of gate bits 0 to 5 drives exactly its own pin
    for (int i = 0; i < 6; i++) begin
      wr(1'b0, 16'h0001 << i);
      check("gate_pin_walk", 16'h0001 << i, gates());
    end
    // Reserved read-only bits drop, writable bits 8 and 6 take the written one
    wr(1'b0, 16'hf7ff);
    rd(1'b0, 1'b1, 16'h017f, "gate_reg_mask");
    check("gate_pins_all", 16'h003f, gates());
    wr(1'b1, 16'hffff);
    rd(1'b1, 1'b1, 16'h000a, "status_ro");
    check("gates_after_ro", 16'h003f, gates());
    // General gate shuts the register port for good
    wr(1'b0, 16'h0800);
    check("general_gate_on", 16'h0040, gates());
    rd(1'b0, 1'b0, 16'h0000, "gated_read");
    wr(1'b0, 16'h0000);
    check("general_gate_sticky", 16'h0040, gates());
    // Dead startup: nothing answers, divider silent
    bias_done_pin = 1'b0; pll_lock_pin = 1'b0; div_run = 1'b0;
    // Divider stuck high: the synchroniser's low reset level must not read as a toggle
    sysdiv_pin = 1'b1;
    do_reset();
    check("gates_power_cycle", 16'h0000, gates());
    rd(1'b0, 1'b1, 16'h0000, "gate_reg_power_cycle");
    tick(200);
    check("load_req_timeout", 16'h0000, {15'h0, fuse_load_req});
    check("ring_osc_dead", 16'h0001, {15'h0, ring_osc_sel});
    // All three timeouts plus fallback, no ready, no index
    rd(1'b1, 1'b1, 16'h00f0, "status_dead");
    // A late load completion must not mark the part ready
    fuse_load_done = 1'b1;
    tick(1);
    fuse_load_done = 1'b0;
    rd(1'b1, 1'b1, 16'h00f0, "status_late_done");
    print_verdict();
  end

endmodule : testbench
`default_nettype wire
